/* File: inc/cspc_pkg.sv */
// constants and types for the storage and pin cell block
// Operation
// (R1) pin reaches core direct or registered
// (R2) pin register on shared edge rising clock
// (R3) configuration load and array reset clear storage
// (R4) output buffer: always, never, or logic enabled
// (R5) storage element is latch or flip-flop
// (R6) data from first output, clock selectable
// (R7) clock source and polarity set per cell
// (R8) reset term in data gives synchronous reset
// (R9) feedback with enable gives clock enable
// (R10) parallel load mux, optionally enable dependent
// (R11) simultaneous set/reset: hold, set, reset dominant
// (R12) input and output polarity freely invertible
// (R13) common clock, derived clocks still allowed
// (R14) async set and reset, reset dominant
// (R15) latch follows data while enable active
`default_nettype none
package cspc_pkg;
  // clock or load-enable source of the logic unit
  typedef enum logic [1:0]
  {
    CSPC_SRC_K,
    CSPC_SRC_C,
    CSPC_SRC_G,
    CSPC_SRC_CORE
  } cspc_src_e;
  // pin output buffer configuration
  typedef enum logic [1:0]
  {
    CSPC_BUF_OFF,
    CSPC_BUF_ON,
    CSPC_BUF_LOGIC
  } cspc_buf_e;
  // behaviour when set and reset coincide
  typedef enum logic [1:0]
  {
    CSPC_SR_HOLD,
    CSPC_SR_SET,
    CSPC_SR_RST
  } cspc_sr_e;
  // value that every storage element is cleared to
  localparam logic CSPC_CLEAR_VAL = 1'h0;
  // value a set drives into storage
  localparam logic CSPC_SET_VAL = 1'h1;
endpackage
`default_nettype wire

/* File: logic/cspc_cell.sv */
// storage element of one configurable logic unit plus one pin cell
`default_nettype none
module cspc_cell
(
  // clock, reset, freeze
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // array-wide clears
  input wire logic i_cfg_load,
  input wire logic i_array_rst_n,
  // logic unit data and clock sources
  input wire logic i_lut_f,
  input wire logic i_lut_g,
  input wire logic i_pin_k,
  input wire logic i_pin_c,
  // logic unit configuration
  input wire logic i_mode_latch,
  input wire cspc_pkg::cspc_src_e i_clk_src,
  input wire logic i_clk_inv,
  input wire logic i_f_inv,
  input wire logic i_q_inv,
  // synchronous controls folded into the data function
  input wire logic i_ce_use,
  input wire logic i_ce_in,
  input wire logic i_srst_use,
  input wire logic i_srst_in,
  input wire logic i_sset_in,
  input wire logic i_sr_dep_ce,
  input wire cspc_pkg::cspc_sr_e i_sr_mode,
  input wire logic i_pload_in,
  input wire logic i_pload_data,
  input wire logic i_pload_dep_ce,
  // asynchronous set and reset of the storage element
  input wire logic i_aset,
  input wire logic i_arst,
  // logic unit output
  output logic o_q,
  // pin interface cell
  input wire logic i_pin_in,
  input wire logic i_in_reg_sel,
  input wire logic i_edge_clk,
  input wire cspc_pkg::cspc_buf_e i_buf_mode,
  input wire logic i_out_data,
  input wire logic i_out_en,
  output logic o_core_in,
  output logic o_pin_out,
  output logic o_pin_oe
);

  // whole block state in one record
  typedef struct packed
  {
    logic q;         // storage element
    logic en_prev;   // last level of the chosen clock
    logic edge_prev; // last level of the die edge clock
    logic pin_reg;   // pin input register
    logic core_in;   // pin value toward core
    logic pin_out;   // pin output data
    logic pin_oe;    // pin output enable
    logic q_out;     // polarity-adjusted output
    logic armed;     // edge history holds a real level
  } cspc_state_s;

  cspc_state_s st;
  cspc_state_s next_st;
  logic clr;      // any array-wide clear
  logic src_lvl;  // selected clock source, raw
  logic en_lvl;   // clock/load enable at active sense
  logic clk_edge; // rising edge of the chosen clock
  logic load;     // storage takes d this cycle
  logic ce_act;   // clock enable satisfied
  logic f_val;    // data function after polarity
  logic s_term;   // synchronous set request
  logic r_term;   // synchronous reset request
  logic d_val;    // final data into storage
  logic pin_edge; // rising edge of the die edge clock

  // next-state logic for both cells
  always_comb
  begin
    next_st = st;
    clr = i_cfg_load | ~i_array_rst_n;
    // per-cell clock choice and sense
    case (i_clk_src)
      cspc_pkg::CSPC_SRC_K: src_lvl = i_pin_k; // R6
      cspc_pkg::CSPC_SRC_C: src_lvl = i_pin_c; // R6
      cspc_pkg::CSPC_SRC_G: src_lvl = i_lut_g; // R6
      default: src_lvl = 1'h1;
    endcase
    en_lvl = src_lvl ^ i_clk_inv; // R7
    // common clock fires every cycle, no skew hazard
    clk_edge = (i_clk_src == cspc_pkg::CSPC_SRC_CORE) ?
      1'h1 : (en_lvl & ~st.en_prev & st.armed); // R13
    load = i_mode_latch ? en_lvl : clk_edge; // R5 R15
    f_val = i_lut_f ^ i_f_inv; // R12
    ce_act = ~i_ce_use | i_ce_in;
    // feedback holds q while enable is inactive
    d_val = ce_act ? f_val : st.q; // R9
    // parallel load path in front of data
    if (i_pload_in && (ce_act || !i_pload_dep_ce))
    begin
      d_val = i_pload_data; // R10
    end
    s_term = i_sset_in & (ce_act | ~i_sr_dep_ce);
    r_term = i_srst_use & i_srst_in & (ce_act | ~i_sr_dep_ce);
    // set/reset terms outrank the other data terms
    if (s_term && r_term)
    begin
      case (i_sr_mode)
        cspc_pkg::CSPC_SR_SET: d_val = cspc_pkg::CSPC_SET_VAL; // R11
        cspc_pkg::CSPC_SR_RST: d_val = cspc_pkg::CSPC_CLEAR_VAL; // R11
        default: d_val = st.q; // R11
      endcase
    end
    else if (r_term)
    begin
      d_val = cspc_pkg::CSPC_CLEAR_VAL; // R8
    end
    else if (s_term)
    begin
      d_val = cspc_pkg::CSPC_SET_VAL;
    end
    if (load)
    begin
      next_st.q = d_val;
    end
    // async controls act in the same cycle, reset first
    if (i_arst)
    begin
      next_st.q = cspc_pkg::CSPC_CLEAR_VAL; // R14
    end
    else if (i_aset)
    begin
      next_st.q = cspc_pkg::CSPC_SET_VAL; // R14
    end
    next_st.en_prev = en_lvl;
    // pin input register on the shared edge clock
    pin_edge = i_edge_clk & ~st.edge_prev & st.armed;
    next_st.edge_prev = i_edge_clk;
    if (pin_edge)
    begin
      next_st.pin_reg = i_pin_in; // R2
    end
    next_st.core_in = i_in_reg_sel ? next_st.pin_reg : i_pin_in; // R1
    // buffer mode decides who drives the pin
    next_st.pin_out = i_out_data;
    case (i_buf_mode)
      cspc_pkg::CSPC_BUF_ON: next_st.pin_oe = 1'h1; // R4
      cspc_pkg::CSPC_BUF_LOGIC: next_st.pin_oe = i_out_en; // R4
      default: next_st.pin_oe = 1'h0; // R4
    endcase
    // array clear wins over everything else
    if (clr)
    begin
      next_st = '0; // R3
      next_st.en_prev = en_lvl;
      next_st.edge_prev = i_edge_clk;
    end
    // reset leaves no history, so a high level must not read as a rise
    next_st.armed = 1'h1;
    next_st.q_out = next_st.q ^ i_q_inv; // R12
  end

  // state register, frozen while i_ce is low
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else if (i_ce)
    begin
      st <= next_st;
    end
  end

  // outputs come straight from state
  assign o_q = st.q_out;
  assign o_core_in = st.core_in;
  assign o_pin_out = st.pin_out;
  assign o_pin_oe = st.pin_oe;

  // direct input path follows the pin
  property p_direct;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && !i_in_reg_sel |=> o_core_in == $past(i_pin_in);
  endproperty
  a_direct: assert property (p_direct) // R1
    else $error("direct pin input not passed to core");

  // registered input only changes on an edge clock rise
  property p_pin_reg;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && i_in_reg_sel && !pin_edge ##1
      i_ce && !clr && i_in_reg_sel && !pin_edge |=> $stable(o_core_in);
  endproperty
  a_pin_reg: assert property (p_pin_reg) // R2
    else $error("registered input changed without edge clock");

  // a clear empties all storage
  property p_clear;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && clr |=> st.q == cspc_pkg::CSPC_CLEAR_VAL && !o_core_in
      && o_q == $past(i_q_inv);
  endproperty
  a_clear: assert property (p_clear) // R3
    else $error("array clear did not clear storage");

  // output enable matches buffer mode
  property p_buf;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr |=> o_pin_oe ==
      ($past(i_buf_mode) == cspc_pkg::CSPC_BUF_ON ||
      ($past(i_buf_mode) == cspc_pkg::CSPC_BUF_LOGIC && $past(i_out_en)));
  endproperty
  a_buf: assert property (p_buf) // R4
    else $error("pin output enable disagrees with mode");

  // latch is transparent while enable is active
  property p_latch_open;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && i_mode_latch && en_lvl && !i_arst && !i_aset
      |=> st.q == $past(d_val) && o_q == (st.q ^ $past(i_q_inv));
  endproperty
  a_latch_open: assert property (p_latch_open) // R15
    else $error("latch not transparent while enabled");

  // no load, no change, in either storage mode
  property p_hold;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && !load && !i_arst && !i_aset |=> $stable(st.q);
  endproperty
  a_hold: assert property (p_hold) // R5
    else $error("storage changed without load");

  // flip-flop loads only on a rise of the chosen clock
  property p_edge;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && $past(i_ce) && !clr && !i_mode_latch
      && i_clk_src != cspc_pkg::CSPC_SRC_CORE && load |-> $rose(en_lvl);
  endproperty
  a_edge: assert property (p_edge) // R6
    else $error("flip-flop loaded off the active edge");

  // async reset dominates async set
  property p_async;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && i_arst |=> st.q == cspc_pkg::CSPC_CLEAR_VAL;
  endproperty
  a_async: assert property (p_async) // R14
    else $error("async reset did not clear storage");

  // synchronous reset term clears on load
  property p_srst;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && load && r_term && !s_term && !i_aset
      |=> st.q == cspc_pkg::CSPC_CLEAR_VAL;
  endproperty
  a_srst: assert property (p_srst) // R8
    else $error("synchronous reset did not clear storage");

  // inactive enable holds value
  property p_ce_hold;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && !ce_act && !i_pload_in && !s_term && !r_term
      && !i_arst && !i_aset |=> $stable(st.q);
  endproperty
  a_ce_hold: assert property (p_ce_hold) // R9
    else $error("storage changed with clock enable inactive");

  // coincident set and reset follow the configured choice
  property p_sr_both;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && load && s_term && r_term && !i_arst && !i_aset
      |=> st.q == (($past(i_sr_mode) == cspc_pkg::CSPC_SR_SET) ? 1'h1 :
      ($past(i_sr_mode) == cspc_pkg::CSPC_SR_RST) ? 1'h0 : $past(st.q));
  endproperty
  a_sr_both: assert property (p_sr_both) // R11
    else $error("simultaneous set/reset handled wrongly");

  // parallel load reaches storage
  property p_pload;
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !clr && load && i_pload_in && !i_pload_dep_ce && !s_term
      && !r_term && !i_arst && !i_aset |=> st.q == $past(i_pload_data);
  endproperty
  a_pload: assert property (p_pload) // R10
    else $error("parallel load value not stored");

endmodule
`default_nettype wire

/* File: verification/cspc_board.sv */
// board logic on the package pin of the pin interface cell
`default_nettype none
module cspc_board
(
  // clock
  input wire logic i_core_clk,
  // device pin drive
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  // board drive
  input wire logic i_drv_en,
  input wire logic i_drv_val,
  // resolved pin level
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'h0; // last resolved level
  // a floating pin shows the inverse, never a stale copy
  always_ff @(posedge i_core_clk)
    last <= o_pin;
  // device drive wins while its enable is high
  assign o_pin = i_pin_oe ? i_pin_out :
    (i_drv_en ? i_drv_val : ~last);
endmodule
`default_nettype wire

/* File: verification/cspc_cell_tb_top.sv */
// self-checking bench for the storage and pin cell
`default_nettype none
module cspc_cell_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ce, cfg, arn, f, g, k, c, lat, ck_inv, f_inv, q_inv;
  logic ce_use, ce_in, sr_use, sr_in, ss_in, sr_dce, pl_in, pl_d, pl_dce;
  logic aset, arst, rsel, eclk, od, oen, den, dval, pin, q, cin, pout, poe;
  cspc_pkg::cspc_src_e src;
  cspc_pkg::cspc_sr_e srm;
  cspc_pkg::cspc_buf_e bm;
  int errors, checked, cyc;
  // device under test
  cspc_cell u_cspc_cell (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_cfg_load(cfg), .i_array_rst_n(arn), .i_lut_f(f), .i_lut_g(g),
    .i_pin_k(k), .i_pin_c(c), .i_mode_latch(lat), .i_clk_src(src),
    .i_clk_inv(ck_inv), .i_f_inv(f_inv), .i_q_inv(q_inv),
    .i_ce_use(ce_use), .i_ce_in(ce_in), .i_srst_use(sr_use),
    .i_srst_in(sr_in), .i_sset_in(ss_in), .i_sr_dep_ce(sr_dce),
    .i_sr_mode(srm), .i_pload_in(pl_in), .i_pload_data(pl_d),
    .i_pload_dep_ce(pl_dce), .i_aset(aset), .i_arst(arst), .o_q(q),
    .i_pin_in(pin), .i_in_reg_sel(rsel), .i_edge_clk(eclk),
    .i_buf_mode(bm), .i_out_data(od), .i_out_en(oen), .o_core_in(cin),
    .o_pin_out(pout), .o_pin_oe(poe));
  // board side of the pin
  cspc_board u_cspc_board (.i_core_clk(clk), .i_pin_out(pout),
    .i_pin_oe(poe), .i_drv_en(den), .i_drv_val(dval), .o_pin(pin));
  // 100 ns clock
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // hang guard, run needs well under a hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      end_of_test();
    end
  end
  // compare and count
  task automatic chk(input logic s, input logic e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one enabled edge, then look at the stored output
  task automatic tq(input logic e);
    @(negedge clk);
    chk(q, e);
  endtask
  // simultaneous set and reset under one mode
  task automatic sr(input cspc_pkg::cspc_sr_e m, input logic e);
    srm = m;
    tq(e);
  endtask
  // verdict
  task automatic end_of_test;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence, inputs change at falling edges only
  initial
  begin
    {rst, ce, arn, den} = 4'hf;
    {cfg, f, g, k, c, lat, ck_inv, f_inv, q_inv} = 9'h000;
    {ce_use, ce_in, sr_use, sr_in, ss_in, sr_dce, pl_in, pl_d} = 8'h00;
    {pl_dce, aset, arst, rsel, eclk, od, oen, dval} = 8'h00;
    src = cspc_pkg::CSPC_SRC_CORE;
    srm = cspc_pkg::CSPC_SR_HOLD;
    bm = cspc_pkg::CSPC_BUF_OFF;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(q, 1'h0);
    chk(poe, 1'h0);
    rst = 1'h0;
    f = 1'h1;
    tq(1'h1);
    q_inv = 1'h1;
    tq(1'h0);
    q_inv = 1'h0;
    f_inv = 1'h1;
    tq(1'h0);
    // flip-flop on a dedicated pin, no edge means hold
    {f_inv, f} = 2'h0;
    src = cspc_pkg::CSPC_SRC_K;
    tq(1'h0);
    f = 1'h1;
    tq(1'h0);
    k = 1'h1;
    tq(1'h1);
    f = 1'h0;
    tq(1'h1);
    // inverted second pin loads on its falling level change
    src = cspc_pkg::CSPC_SRC_C;
    {ck_inv, f} = 2'h3;
    tq(1'h1);
    {c, f} = 2'h2;
    tq(1'h1);
    c = 1'h0;
    tq(1'h0);
    // latch on the second function output
    src = cspc_pkg::CSPC_SRC_G;
    {lat, ck_inv, g, f} = 4'hb;
    tq(1'h1);
    f = 1'h0;
    tq(1'h0);
    f = 1'h1;
    tq(1'h1);
    {g, f} = 2'h0;
    tq(1'h1);
    // synchronous controls on the common clock
    // data low with enable off: the stored one must stay
    src = cspc_pkg::CSPC_SRC_CORE;
    {lat, f, ce_use} = 3'h1;
    tq(1'h1);
    ce_in = 1'h1;
    tq(1'h0);
    f = 1'h1;
    tq(1'h1);
    {ce_in, sr_use, sr_in, ss_in} = 4'h7;
    sr(cspc_pkg::CSPC_SR_HOLD, 1'h1);
    sr(cspc_pkg::CSPC_SR_RST, 1'h0);
    sr(cspc_pkg::CSPC_SR_HOLD, 1'h0);
    sr(cspc_pkg::CSPC_SR_SET, 1'h1);
    ss_in = 1'h0;
    tq(1'h0);
    {sr_dce, sr_in, ss_in} = 3'h5;
    tq(1'h0);
    {sr_use, ss_in, pl_in, pl_d} = 4'h3;
    tq(1'h1);
    {pl_dce, pl_d} = 2'h2;
    tq(1'h1);
    {pl_in, ce_use, aset, f} = 4'h2;
    tq(1'h1);
    arst = 1'h1;
    tq(1'h0);
    {aset, arst, f} = 3'h1;
    tq(1'h1);
    // freeze: i_ce low holds every flop
    ce = 1'h0;
    f = 1'h0;
    tq(1'h1);
    ce = 1'h1;
    tq(1'h0);
    f = 1'h1;
    tq(1'h1);
    // mid-run reset with the pin clock high: no false edge after it
    rst = 1'h1;
    src = cspc_pkg::CSPC_SRC_K;
    tq(1'h0);
    rst = 1'h0;
    tq(1'h0);
    tq(1'h0);
    src = cspc_pkg::CSPC_SRC_CORE;
    tq(1'h1);
    // both clears beat the data path
    cfg = 1'h1;
    tq(1'h0);
    cfg = 1'h0;
    tq(1'h1);
    arn = 1'h0;
    tq(1'h0);
    arn = 1'h1;
    // pin input, direct then registered on the edge clock
    dval = 1'h1;
    @(negedge clk);
    chk(cin, 1'h1);
    {rsel, dval} = 2'h2;
    @(negedge clk);
    dval = 1'h1;
    @(negedge clk);
    chk(cin, 1'h0);
    eclk = 1'h1;
    @(negedge clk);
    chk(cin, 1'h1);
    dval = 1'h0;
    @(negedge clk);
    chk(cin, 1'h1);
    // output buffer modes, board released, pin loops back
    {rsel, den, od} = 3'h1;
    bm = cspc_pkg::CSPC_BUF_ON;
    @(negedge clk);
    chk(poe, 1'h1);
    chk(pout, 1'h1);
    @(negedge clk);
    chk(cin, 1'h1);
    bm = cspc_pkg::CSPC_BUF_LOGIC;
    @(negedge clk);
    chk(poe, 1'h0);
    oen = 1'h1;
    @(negedge clk);
    chk(poe, 1'h1);
    bm = cspc_pkg::CSPC_BUF_OFF;
    @(negedge clk);
    chk(poe, 1'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
